// ### irm_cfg.svh
// Constants for the input reference monitor and selector.
// Assumes a 10 MHz core clock and an 8-bit register port.
`ifndef IRM_CFG_SVH
`define IRM_CFG_SVH
// ==========================================================
// Timing
`define IRM_CLK_NS      100
`define IRM_WIN_NS      6400
`define IRM_WIN_CYC     (`IRM_WIN_NS / `IRM_CLK_NS)
// ==========================================================
// Register offsets
`define IRM_A_DIV       8'h08
`define IRM_A_CHCFG     8'h10
`define IRM_A_FREQ      8'h18
`define IRM_A_BKT       8'h20
`define IRM_A_RATE34    8'h34
`define IRM_A_RATE38    8'h38
`define IRM_A_RATE64    8'h64
`define IRM_A_ACTIVE    8'h40
`define IRM_A_ALARM     8'h41
`define IRM_A_LOST      8'h42
`define IRM_A_SEL       8'h43
`define IRM_A_MONEN     8'h44
// ==========================================================
// Field positions
`define IRM_B_RATE34    2
`define IRM_B_RATE38A   5
`define IRM_B_RATE38B   6
`define IRM_B_RATE64    4
// ==========================================================
// Channel numbers
`define IRM_CH_SEC1     4'h3
`define IRM_CH_SEC2     4'h4
`define IRM_CH_DIF1     4'h5
`define IRM_CH_DIF2     4'h6
`define IRM_CH_SYNC1    4'h7
`define IRM_CH_SYNC2    4'h8
`define IRM_CH_STBY     4'h9
`define IRM_CH_SYNC3    4'ha
// ==========================================================
// Reset values
`define IRM_PRIO_SEC1   4'h2
`define IRM_PRIO_SEC2   4'h3
`define IRM_PRIO_DIFF   4'h0
`define IRM_PRIO_STBY   4'h4
`define IRM_BKT_SIZE    8'h08
`define IRM_BKT_SET     8'h04
`define IRM_BKT_CLR     8'h01
`define IRM_BKT_LEAK    8'h04
`define IRM_DIV_RST     8'h01
`endif

// ### irm_pkg.sv
// Types for the input reference monitor and selector.
// Assumes irm_cfg.svh is on the include path.
package irm_pkg;
  // ==========================================================
  // Locking modes
  typedef enum logic [1:0] {
    IRM_DIRECT    = 2'h0,
    IRM_REDUCE_8K = 2'h1,
    IRM_DIVIDE_N  = 2'h2
  } irm_mode_t;
  // ==========================================================
  // Spot frequency codes
  typedef enum logic [3:0] {
    IRM_F_8K    = 4'h0,
    IRM_F_E1T1  = 4'h1,
    IRM_F_6M48  = 4'h2,
    IRM_F_19M44 = 4'h3,
    IRM_F_25M92 = 4'h4,
    IRM_F_38M88 = 4'h5,
    IRM_F_51M84 = 4'h6,
    IRM_F_77M76 = 4'h7,
    IRM_F_155M  = 4'h8,
    IRM_F_2K    = 4'h9,
    IRM_F_4K    = 4'ha
  } irm_freq_t;
  // ==========================================================
  // Strap capture sequence, one-hot
  typedef enum logic [3:0] {
    IRM_ST_WAIT1 = 4'b0001,
    IRM_ST_WAIT2 = 4'b0010,
    IRM_ST_LOAD  = 4'b0100,
    IRM_ST_RUN   = 4'b1000
  } irm_strap_t;
  // ==========================================================
  // Whole state of the block
  typedef struct packed {
    logic [8:0]      meta;
    logic [8:0]      stab;
    logic [8:0]      prev;
    logic [4:0][3:0] prio;
    logic [4:0][1:0] mode;
    logic [4:0][1:0] bid;
    logic [4:0][3:0] freq;
    logic [4:0][7:0] div_ratio;
    logic [3:0][7:0] bsize;
    logic [3:0][7:0] bset;
    logic [3:0][7:0] bclr;
    logic [3:0][7:0] bleak;
    logic [4:0][7:0] bucket;
    logic [4:0][7:0] leak_cnt;
    logic [4:0]      alarm;
    logic [4:0]      seen;
    logic [4:0]      active;
    logic [4:0]      lost;
    logic [4:0]      mon_en;
    logic [7:0]      win_cnt;
    logic            rate34;
    logic            rate38a;
    logic            rate38b;
    logic            rate64;
    irm_strap_t      strap;
    logic [2:0]      sel_idx;
    logic            sel_valid;
    logic [3:0]      sel_chan;
    logic [3:0]      sync_chan;
    logic [1:0]      sel_mode;
    logic [7:0]      sel_div;
    logic [3:0]      sel_freq;
    logic            sel_clk;
    logic            sel_sync;
    logic            sw_pulse;
    logic [7:0]      rdata;
  } irm_state_t;
endpackage

// ### irm_input_select.sv
// Input side of a line-card clock protection block: monitors, buckets, selection.
// Assumes a 10 MHz core clock, async pins sampled here, a same-clock register port.
`include "irm_cfg.svh"

module irm_input_select (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       sec1_clock_in,
  input  wire logic       sec2_clock_in,
  input  wire logic       master_clock_differential_input_in,
  input  wire logic       slave_clock_differential_input_in,
  input  wire logic       standby_clock_input_in,
  input  wire logic       sync1_in,
  input  wire logic       sync2_in,
  input  wire logic       sync3_in,
  input  wire logic       input_rate_standard_bit_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            sel_valid_out,
  output logic      [3:0] sel_clock_chan_out,
  output logic      [3:0] sel_sync_chan_out,
  output logic      [1:0] sel_lock_mode_out,
  output logic      [7:0] sel_divider_out,
  output logic      [3:0] sel_freq_code_out,
  output logic            sel_clock_out,
  output logic            sel_sync_out,
  output logic            switch_pulse_out,
  output logic      [4:0] active_out,
  output logic      [4:0] alarm_out,
  output logic            rate_standard_out
);

  // ==========================================================
  // Register map, input index i is 0..4 and bucket b is 0..3
  // Index 0,1 single-ended master/slave, 2,3 differential, 4 stand-by
  // Divider at 0x08+i; a zero is kept as one
  // Config at 0x10+i: bucket id, lock mode, priority
  // Spot frequency code at 0x18+i
  // Bucket size, set, clear, leak at 0x20+4b..0x23+4b
  // Rate bits at 0x34 bit 2, 0x38 bits 5/6, 0x64 bit 4
  // Active bits at 0x40, alarms at 0x41, both read only
  // Sticky lost bits at 0x42, write one to clear
  // Selection status at 0x43, monitor enables at 0x44
  // Unmapped reads return zero, unmapped writes vanish

  // ==========================================================
  // Channel helpers
  // Channel number of an input index
  function automatic logic [3:0] chan_of(input logic [2:0] idx);
    case (idx)
      3'h0:    chan_of = `IRM_CH_SEC1;
      3'h1:    chan_of = `IRM_CH_SEC2;
      3'h2:    chan_of = `IRM_CH_DIF1;
      3'h3:    chan_of = `IRM_CH_DIF2;
      default: chan_of = `IRM_CH_STBY;
    endcase
  endfunction

  // Syncs sit at bits 5..7 of the sampled pin bus
  // Sync pin position paired with an input index
  function automatic logic [2:0] sync_pos(input logic [2:0] idx);
    case (idx)
      3'h0, 3'h2: sync_pos = 3'h5;
      3'h1, 3'h3: sync_pos = 3'h6;
      default:    sync_pos = 3'h7;
    endcase
  endfunction

  // Sync channel number paired with an input index
  function automatic logic [3:0] sync_chan_of(input logic [2:0] idx);
    case (idx)
      3'h0, 3'h2: sync_chan_of = `IRM_CH_SYNC1;
      3'h1, 3'h3: sync_chan_of = `IRM_CH_SYNC2;
      default:    sync_chan_of = `IRM_CH_SYNC3;
    endcase
  endfunction

  // Differential ports are indices 2 and 3
  function automatic logic is_diff(input logic [2:0] idx);
    is_diff = (idx == 3'h2) || (idx == 3'h3);
  endfunction

  // Last cycle of one activity window
  localparam logic [7:0] WIN_LAST = 8'(`IRM_WIN_CYC - 1);

  irm_pkg::irm_state_t s;
  irm_pkg::irm_state_t n;

  // Bit 8 is the strap, bits 5..7 the group syncs
  logic [8:0] pins;
  assign pins = {input_rate_standard_bit_in, sync3_in, sync2_in, sync1_in,
                 standby_clock_input_in, slave_clock_differential_input_in,
                 master_clock_differential_input_in, sec2_clock_in, sec1_clock_in};

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [4:0] edge_seen;
    logic [4:0] avail;
    logic [2:0] best;
    logic       found;
    logic [1:0] id;
    logic [2:0] ci;
    logic       win_end;

    edge_seen = '0;
    avail     = '0;
    best      = 3'h0;
    found     = 1'b0;
    id        = 2'h0;
    ci        = 3'h0;
    win_end   = 1'b0;
    n          = s;
    n.sw_pulse = 1'b0;
    n.rdata    = 8'h00;

    // Limitation: a 10 MHz core only sees inputs well
    // below 5 MHz; faster clocks alias in the monitor
    // Two-flop sampling; first stage feeds only the second
    n.meta = pins;
    n.stab = s.meta;
    n.prev = s.stab;
    edge_seen = s.stab[4:0] ^ s.prev[4:0];
    win_end   = (s.win_cnt == WIN_LAST);
    n.win_cnt = win_end ? 8'h00 : s.win_cnt + 8'h01;

    // Register writes go first so monitor events below win over clears
    if (reg_wr_in) begin
      for (int c = 0; c < 5; c++) begin
        ci = 3'(c);
        // Mode 3 is no locking mode; the old mode stays
        if (reg_addr_in == `IRM_A_CHCFG + 8'(c)) begin
          n.prio[c] = reg_wdata_in[3:0];
          n.mode[c] = (reg_wdata_in[5:4] == 2'h3) ? s.mode[c] : reg_wdata_in[5:4];
          n.bid[c]  = reg_wdata_in[7:6];
        end
        // A zero ratio would stall the divider, so keep one
        if (reg_addr_in == `IRM_A_DIV + 8'(c))
          n.div_ratio[c] = (reg_wdata_in == 8'h00) ? 8'h01 : reg_wdata_in;
        // Codes past the table, or 155.52 on a single-ended port, are dropped
        if (reg_addr_in == `IRM_A_FREQ + 8'(c)) begin
          if (reg_wdata_in[3:0] == irm_pkg::IRM_F_155M) begin
            if (is_diff(ci))
              n.freq[c] = reg_wdata_in[3:0];
          end else if (reg_wdata_in[3:0] <= irm_pkg::IRM_F_4K) begin
            n.freq[c] = reg_wdata_in[3:0];
          end
        end
      end
      // Four shared bucket configs, four bytes each
      for (int b = 0; b < 4; b++) begin
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b))     n.bsize[b] = reg_wdata_in;
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b + 1)) n.bset[b]  = reg_wdata_in;
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b + 2)) n.bclr[b]  = reg_wdata_in;
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b + 3)) n.bleak[b] = reg_wdata_in;
      end
      case (reg_addr_in)
        // Rate bits stay writable after the strap load
        `IRM_A_RATE34: n.rate34 = reg_wdata_in[`IRM_B_RATE34];
        `IRM_A_RATE38: begin
          n.rate38a = reg_wdata_in[`IRM_B_RATE38A];
          n.rate38b = reg_wdata_in[`IRM_B_RATE38B];
        end
        `IRM_A_RATE64: n.rate64 = reg_wdata_in[`IRM_B_RATE64];
        `IRM_A_LOST:   n.lost   = s.lost & ~reg_wdata_in[4:0];
        `IRM_A_MONEN:  n.mon_en = reg_wdata_in[4:0];
        default: ;
      endcase
    end

    // A window without any edge counts one anomaly;
    // busy windows drain the bucket at the leak rate.
    // Buckets saturate at their size so recovery time
    // stays bounded however long an input was dead.
    // Lost bits are set last, so a clear never hides one
    // Activity windows and leaky buckets, one per input
    for (int c = 0; c < 5; c++) begin
      id = s.bid[c];
      n.seen[c] = s.seen[c] | edge_seen[c];
      if (win_end) begin
        n.seen[c]   = 1'b0;
        n.active[c] = s.seen[c] | edge_seen[c];
        if (!(s.seen[c] | edge_seen[c])) begin
          n.lost[c] = 1'b1;
          if (s.bucket[c] < s.bsize[id])
            n.bucket[c] = s.bucket[c] + 8'h01;
        end else if (s.leak_cnt[c] + 8'h01 >= s.bleak[id]) begin
          n.leak_cnt[c] = 8'h00;
          if (s.bucket[c] != 8'h00)
            n.bucket[c] = s.bucket[c] - 8'h01;
        end else begin
          n.leak_cnt[c] = s.leak_cnt[c] + 8'h01;
        end
      end
      // Hysteresis between set and clear levels
      // The gap keeps the alarm from chattering
      if (s.bucket[c] >= s.bset[id])
        n.alarm[c] = 1'b1;
      else if (s.bucket[c] <= s.bclr[id])
        n.alarm[c] = 1'b0;
    end

    // Strap is sampled only after it has cleared the synchroniser
    // Software writes before the load are overwritten
    case (s.strap)
      irm_pkg::IRM_ST_WAIT1: n.strap = irm_pkg::IRM_ST_WAIT2;
      irm_pkg::IRM_ST_WAIT2: n.strap = irm_pkg::IRM_ST_LOAD;
      irm_pkg::IRM_ST_LOAD: begin
        n.rate34  = s.stab[8];
        n.rate38a = s.stab[8];
        n.rate38b = s.stab[8];
        n.rate64  = s.stab[8];
        n.strap   = irm_pkg::IRM_ST_RUN;
      end
      irm_pkg::IRM_ST_RUN:   n.strap = irm_pkg::IRM_ST_RUN;
      default:               n.strap = irm_pkg::IRM_ST_WAIT1;
    endcase

    // Priority selection over available inputs
    // Ties go to the lower index; priority 0 is never
    // picked, so a zero parks an input for manual use.
    // With nothing eligible the old index is kept and
    // the valid flag and the clock and sync outputs drop.
    // Alarms only count where their monitor is enabled
    for (int c = 0; c < 5; c++) begin
      avail[c] = s.active[c] & ~(s.mon_en[c] & s.alarm[c]);
      if (avail[c] && s.prio[c] != 4'h0 && (!found || s.prio[c] < s.prio[best])) begin
        found = 1'b1;
        best  = 3'(c);
      end
    end
    n.sel_valid = found;
    n.sel_idx   = found ? best : s.sel_idx;
    // One-cycle pulse on any change of the selection
    if (found != s.sel_valid || (found && best != s.sel_idx))
      n.sw_pulse = 1'b1;
    // Clock and sync move together as one group
    n.sel_chan  = chan_of(n.sel_idx);
    n.sync_chan = sync_chan_of(n.sel_idx);
    n.sel_mode  = s.mode[n.sel_idx];
    n.sel_div   = s.div_ratio[n.sel_idx];
    n.sel_freq  = s.freq[n.sel_idx];
    n.sel_clk   = found & s.stab[n.sel_idx];
    n.sel_sync  = found & s.stab[sync_pos(n.sel_idx)];

    // Read data, one cycle after the strobe
    // Zero outside the answer cycle lets several
    // slaves share one OR'ed read bus.
    // Reads have no side effects on any status bit
    if (reg_rd_in) begin
      for (int c = 0; c < 5; c++) begin
        if (reg_addr_in == `IRM_A_CHCFG + 8'(c)) n.rdata = {s.bid[c], s.mode[c], s.prio[c]};
        if (reg_addr_in == `IRM_A_DIV + 8'(c))   n.rdata = s.div_ratio[c];
        if (reg_addr_in == `IRM_A_FREQ + 8'(c))  n.rdata = {4'h0, s.freq[c]};
      end
      for (int b = 0; b < 4; b++) begin
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b))     n.rdata = s.bsize[b];
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b + 1)) n.rdata = s.bset[b];
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b + 2)) n.rdata = s.bclr[b];
        if (reg_addr_in == `IRM_A_BKT + 8'(4 * b + 3)) n.rdata = s.bleak[b];
      end
      case (reg_addr_in)
        `IRM_A_RATE34: n.rdata = {5'h00, s.rate34, 2'h0};
        `IRM_A_RATE38: n.rdata = {1'b0, s.rate38b, s.rate38a, 5'h00};
        `IRM_A_RATE64: n.rdata = {3'h0, s.rate64, 4'h0};
        `IRM_A_ACTIVE: n.rdata = {3'h0, s.active};
        `IRM_A_ALARM:  n.rdata = {3'h0, s.alarm};
        `IRM_A_LOST:   n.rdata = {3'h0, s.lost};
        `IRM_A_SEL:    n.rdata = {s.sel_valid, 1'b0, s.sel_idx == 3'h4, 1'b0, s.sel_chan};
        `IRM_A_MONEN:  n.rdata = {3'h0, s.mon_en};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // State register; reset puts every setting back to default
  // Defaults follow the channel table; the strap bits
  // wait for the load a few edges after release.
  // Only constants in the async branch
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s          <= '0;
      s.prio     <= {`IRM_PRIO_STBY, `IRM_PRIO_DIFF, `IRM_PRIO_DIFF,
                     `IRM_PRIO_SEC2, `IRM_PRIO_SEC1};
      s.freq     <= {irm_pkg::IRM_F_19M44, irm_pkg::IRM_F_19M44, irm_pkg::IRM_F_19M44,
                     irm_pkg::IRM_F_8K, irm_pkg::IRM_F_8K};
      s.div_ratio <= {5{`IRM_DIV_RST}};
      s.bsize    <= {4{`IRM_BKT_SIZE}};
      s.bset     <= {4{`IRM_BKT_SET}};
      s.bclr     <= {4{`IRM_BKT_CLR}};
      s.bleak    <= {4{`IRM_BKT_LEAK}};
      s.mon_en   <= 5'h1f;
      s.strap    <= irm_pkg::IRM_ST_WAIT1;
      s.sel_chan <= `IRM_CH_SEC1;
      s.sync_chan <= `IRM_CH_SYNC1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  // Nothing combinational reaches a pin, so no
  // glitches are carried into the loop logic
  assign reg_rdata_out      = s.rdata;
  assign sel_valid_out      = s.sel_valid;
  assign sel_clock_chan_out = s.sel_chan;
  assign sel_sync_chan_out  = s.sync_chan;
  assign sel_lock_mode_out  = s.sel_mode;
  assign sel_divider_out    = s.sel_div;
  assign sel_freq_code_out  = s.sel_freq;
  assign sel_clock_out      = s.sel_clk;
  assign sel_sync_out       = s.sel_sync;
  assign switch_pulse_out   = s.sw_pulse;
  assign active_out         = s.active;
  assign alarm_out          = s.alarm;
  assign rate_standard_out  = s.rate34;

endmodule

// ### irm_input_select_assertions.sv
// Checker for the input selector, built only on the ports of its top module.
// Assumes it is bound into irm_input_select from the bench's top file.
module irm_input_select_assertions (
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       input_rate_standard_bit_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       sel_valid_out,
  input wire logic [3:0] sel_clock_chan_out,
  input wire logic [3:0] sel_sync_chan_out,
  input wire logic       sel_clock_out,
  input wire logic       sel_sync_out,
  input wire logic       switch_pulse_out,
  input wire logic [4:0] active_out,
  input wire logic       rate_standard_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Helper logic
  logic [2:0] run_cnt;

  // Edges since release; saturates so the strap check fires only once
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_cnt <= 3'h0;
    end else if (run_cnt != 3'h7) begin
      run_cnt <= run_cnt + 3'h1;
    end
  end

  // Group sync paired with a clock channel; f marks an illegal channel
  function automatic logic [3:0] sync_of(input logic [3:0] ch);
    case (ch)
      4'h3, 4'h5: sync_of = 4'h7;
      4'h4, 4'h6: sync_of = 4'h8;
      4'h9:       sync_of = 4'ha;
      default:    sync_of = 4'hf;
    endcase
  endfunction

  // Input index behind a clock channel
  function automatic logic [2:0] idx_of(input logic [3:0] ch);
    case (ch)
      4'h4:    idx_of = 3'h1;
      4'h5:    idx_of = 3'h2;
      4'h6:    idx_of = 3'h3;
      4'h9:    idx_of = 3'h4;
      default: idx_of = 3'h0;
    endcase
  endfunction

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_read(a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  // Writes to the rate bit only count once the strap load is over
  sequence s_rate_write;
    reg_wr_in && reg_addr_in == 8'h34 && run_cnt == 3'h7;
  endsequence

  a_sync_paired: assert property (sel_sync_chan_out == sync_of(sel_clock_chan_out))
    else $error("sync channel not paired with clock channel");
  a_switch_pulse: assert property (switch_pulse_out ==
      ($changed(sel_clock_chan_out) || $changed(sel_valid_out)))
    else $error("switch pulse does not match selection change");
  a_valid_active: assert property (sel_valid_out |->
      (($past(active_out) >> idx_of(sel_clock_chan_out)) & 5'h01) == 5'h01)
    else $error("selected input was not active");
  a_idle_outputs: assert property (!sel_valid_out |-> !sel_clock_out && !sel_sync_out)
    else $error("clock or sync passed with nothing selected");
  a_chan_legal: assert property (sel_valid_out |->
      sel_clock_chan_out inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h9})
    else $error("selected channel is not a clock input");
  a_strap_load: assert property (run_cnt == 3'h6 |->
      rate_standard_out == input_rate_standard_bit_in)
    else $error("rate bit not loaded from strap");
  a_rate_write: assert property (s_rate_write |=> rate_standard_out == $past(reg_wdata_in[2]))
    else $error("rate bit write not taken");
  a_rate_hold: assert property (run_cnt == 3'h7 && !(reg_wr_in && reg_addr_in == 8'h34) |=>
      $stable(rate_standard_out))
    else $error("rate bit changed without a write");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read answer");
  a_status_read: assert property (s_read(8'h43) |=> reg_rdata_out == {$past(sel_valid_out),
      1'b0, $past(sel_clock_chan_out) == 4'h9, 1'b0, $past(sel_clock_chan_out)})
    else $error("status byte does not show the selection");
endmodule

// ### irm_clock_sources.sv
// Behavioural model of the timing-card sources: five clocks and three syncs.
// Assumes the core clock only paces its edges; a stopped source sits low.
module irm_clock_sources (
  input  wire logic       core_clk_in,
  input  wire logic [4:0] run_in,
  output logic      [4:0] clk_out,
  output logic      [2:0] sync_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tick = 8'h00;

  // ==========================================================
  // Edge pacing
  // Moves on the falling core edge, well away from the sampling edge
  always @(negedge core_clk_in) begin
    tick <= tick + 8'h01;
  end

  // Slow enough that a 10 MHz monitor sees every edge
  assign clk_out = run_in & {tick[3], tick[2], tick[1], tick[2], tick[1]};
  // Each sync runs while any clock of its group runs
  assign sync_out = {run_in[4], run_in[1] | run_in[3], run_in[0] | run_in[2]} & {3{tick[4]}};
endmodule

// ### tb_top.sv
// Self-checking bench for the input selector: register tests and source failover.
// Assumes the design, its checker and the source model are compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       input_rate_standard_bit_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [4:0] run = 5'h1f;
  logic [4:0] src_clk;
  logic [2:0] src_sync;
  logic [7:0] reg_rdata_out;
  logic       sel_valid_out;
  logic [3:0] sel_clock_chan_out;
  logic [3:0] sel_sync_chan_out;
  logic [1:0] sel_lock_mode_out;
  logic [7:0] sel_divider_out;
  logic [3:0] sel_freq_code_out;
  logic       sel_clock_out;
  logic       sel_sync_out;
  logic       switch_pulse_out;
  logic [4:0] active_out;
  logic [4:0] alarm_out;
  logic       rate_standard_out;
  int         miscompares = 0;
  int         total_checks = 0;
  logic [3:0] prio_exp [5] = '{4'h2, 4'h3, 4'h0, 4'h0, 4'h4};
  logic [3:0] freq_exp [5] = '{4'h0, 4'h0, 4'h3, 4'h3, 4'h3};
  logic [7:0] bkt_exp [4] = '{8'h08, 8'h04, 8'h01, 8'h04};

  // ==========================================================
  // Clock, sources and design
  always #50 core_clk_in = ~core_clk_in;

  irm_clock_sources irm_clock_sources_inst (.core_clk_in, .run_in(run), .clk_out(src_clk),
    .sync_out(src_sync));

  irm_input_select irm_input_select_inst (.core_clk_in, .rst_in,
    .sec1_clock_in(src_clk[0]), .sec2_clock_in(src_clk[1]),
    .master_clock_differential_input_in(src_clk[2]),
    .slave_clock_differential_input_in(src_clk[3]), .standby_clock_input_in(src_clk[4]),
    .sync1_in(src_sync[0]), .sync2_in(src_sync[1]), .sync3_in(src_sync[2]),
    .input_rate_standard_bit_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .sel_valid_out, .sel_clock_chan_out, .sel_sync_chan_out,
    .sel_lock_mode_out, .sel_divider_out, .sel_freq_code_out, .sel_clock_out,
    .sel_sync_out, .switch_pulse_out, .active_out, .alarm_out, .rate_standard_out);

  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    check(reg_rdata_out & m, exp);
  endtask

  // Selection moves at window ends or on config writes, so allow several windows
  task automatic wait_sel(input logic v, input logic [3:0] ch, input logic [3:0] sy);
    @(negedge core_clk_in);
    repeat (600) if ({sel_valid_out, sel_clock_chan_out} !== {v, ch}) @(negedge core_clk_in);
    check({3'h0, sel_valid_out, sel_clock_chan_out}, {3'h0, v, ch});
    check({4'h0, sel_sync_chan_out}, {4'h0, sy});
  endtask

  task automatic reset_run(input logic s);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    input_rate_standard_bit_in <= s;
    repeat (3) @(negedge core_clk_in);
    check({sel_valid_out, alarm_out, switch_pulse_out, rate_standard_out}, 8'h00);
    check({sel_clock_chan_out, sel_sync_chan_out}, 8'h37);
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (10) @(negedge core_clk_in);
    check({7'h0, rate_standard_out}, {7'h0, s});
    rd_chk(8'h34, 8'h04, {5'h0, s, 2'h0});
    rd_chk(8'h38, 8'h60, {1'b0, s, s, 5'h0});
    rd_chk(8'h64, 8'h10, {3'h0, s, 4'h0});
  endtask

  task automatic defaults_chk();
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'h10 + 8'(i), 8'h0f, {4'h0, prio_exp[i]});
      rd_chk(8'h18 + 8'(i), 8'h0f, {4'h0, freq_exp[i]});
    end
    for (int i = 0; i < 16; i++) begin
      rd_chk(8'h20 + 8'(i), 8'hff, bkt_exp[i % 4]);
    end
    rd_chk(8'h44, 8'hff, 8'h1f);
    rd_chk(8'h80, 8'hff, 8'h00);
  endtask

  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    reset_run(1'b1);
    defaults_chk();
    for (int m = 0; m < 3; m++) begin
      wr_reg(8'h10, {2'(m), 2'(m), 4'h2});
      rd_chk(8'h10, 8'hf0, {2'(m), 2'(m), 4'h0});
    end
    wr_reg(8'h10, 8'hb2);
    rd_chk(8'h10, 8'h30, 8'h20);
    wr_reg(8'h10, 8'h12);
    wr_reg(8'h08, 8'h00);
    rd_chk(8'h08, 8'hff, 8'h01);
    wr_reg(8'h08, 8'hfa);
    rd_chk(8'h08, 8'hff, 8'hfa);
    wr_reg(8'h18, 8'h08);
    rd_chk(8'h18, 8'hff, 8'h00);
    wr_reg(8'h18, 8'h07);
    rd_chk(8'h18, 8'hff, 8'h07);
    wr_reg(8'h1a, 8'h08);
    rd_chk(8'h1a, 8'hff, 8'h08);
    wr_reg(8'h1c, 8'h08);
    rd_chk(8'h1c, 8'hff, 8'h03);
    wr_reg(8'h34, 8'h00);
    rd_chk(8'h34, 8'h04, 8'h00);
    check({7'h0, rate_standard_out}, 8'h00);
    wr_reg(8'h38, 8'h00);
    rd_chk(8'h38, 8'h60, 8'h00);
    wr_reg(8'h34, 8'h04);
    @(negedge core_clk_in);
    check({7'h0, rate_standard_out}, 8'h01);
    // All sources up: lowest non-zero priority wins
    wait_sel(1'b1, 4'h3, 4'h7);
    check({6'h0, sel_lock_mode_out}, 8'h01);
    check(sel_divider_out, 8'hfa);
    check({4'h0, sel_freq_code_out}, 8'h07);
    rd_chk(8'h43, 8'hff, 8'h83);
    check({3'h0, active_out}, 8'h1f);
    @(posedge core_clk_in);
    run <= 5'h1e;
    wait_sel(1'b1, 4'h4, 4'h8);
    rd_chk(8'h42, 8'h01, 8'h01);
    repeat (600) if (alarm_out[0] !== 1'b1) @(negedge core_clk_in);
    check({7'h0, alarm_out[0]}, 8'h01);
    @(posedge core_clk_in);
    run <= 5'h1c;
    wait_sel(1'b1, 4'h9, 4'ha);
    rd_chk(8'h43, 8'hff, 8'ha9);
    check({4'h0, sel_freq_code_out}, 8'h03);
    wr_reg(8'h13, 8'h01);
    wait_sel(1'b1, 4'h6, 4'h8);
    @(posedge core_clk_in);
    run <= 5'h00;
    wait_sel(1'b0, 4'h6, 4'h8);
    check({6'h0, sel_clock_out, sel_sync_out}, 8'h00);
    reset_run(1'b0);
    defaults_chk();
    summarize();
  end

  // Cut a hang short; the tests need fewer than a thousand cycles
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
endmodule

bind irm_input_select irm_input_select_assertions irm_input_select_assertions_inst (
  .core_clk_in, .rst_in, .input_rate_standard_bit_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sel_valid_out, .sel_clock_chan_out,
  .sel_sync_chan_out, .sel_clock_out, .sel_sync_out, .switch_pulse_out, .active_out,
  .rate_standard_out);
